// ==== cac_pkg.sv ====
package cac_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_IN = 3;
    localparam int NUM_OUT = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FREQ_W = 24;
    localparam int HALF_W = 8;
    localparam int SKEW_W = 4;
    localparam int PHASE_W = 8;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int LOS_TIME_NS = 1000;
    localparam int LOS_CYC = (LOS_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int CAL_TIME_NS = 20000;
    localparam int CAL_CYC =
        (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PHASE_STEP_PS = 200;
    localparam int SKEW_STEP_MIN_PS = 800;
    localparam int SKEW_STEP_MAX_PS = 2200;

    // ==========================================================
    // register map
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PD_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PHASE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SKEW_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] INT_CLR_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] INT_EN_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] FREQ_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] DIV_OFS = 8'h24;

    // ctrl fields
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_PIN_EN_LSB = 2;
    localparam int CTRL_SEL_LSB = 5;
    localparam int SEL_W = 2;

    // status / interrupt fields
    localparam int ST_LOS_LSB = 0;
    localparam int ST_CAL_BIT = 3;
    localparam int ST_FREEZE_BIT = 4;
    localparam int INT_W = NUM_IN + 1;
    localparam int INT_CAL_BIT = NUM_IN;

    // reset values and bus response codes
    localparam logic [NUM_IN-1:0] PIN_EN_RST = 3'h0;
    localparam logic POL_RST = 1'b0;
    localparam logic [NUM_OUT-1:0] PD_RST = 5'h00;
    localparam logic [PHASE_W-1:0] PHASE_RST = 8'h00;
    localparam logic [HALF_W-1:0] DIV_RST = 8'h04;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic bypass;
        logic polarity;
        logic [NUM_IN-1:0] pin_en;
        logic [SEL_W-1:0] sel;
        logic [NUM_OUT-1:0] pd;
        logic [PHASE_W-1:0] phase;
        logic [NUM_OUT*SKEW_W-1:0] skew;
        logic [HALF_W-1:0] half;
        logic [INT_W-1:0] int_en;
    } cac_cfg_t;

    localparam cac_cfg_t CFG_RST = '{
        bypass: 1'b0,
        polarity: POL_RST,
        pin_en: PIN_EN_RST,
        sel: 2'h0,
        pd: PD_RST,
        phase: PHASE_RST,
        skew: 20'h00000,
        half: DIV_RST,
        int_en: 4'h0
    };

endpackage : cac_pkg

// ==== cac_los_mon.sv ====
`timescale 1ns/1ps
module cac_los_mon import cac_pkg::*; #(
    parameter int LOS_CYCLES = LOS_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_clk_pin,
    output logic ref_level,
    output logic los
);

    if (LOS_CYCLES < 2 || LOS_CYCLES > 65535) begin : g_chk
        $error("cac_los_mon: LOS_CYCLES out of range");
    end

    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic [15:0] cnt;
        logic los;
    } cac_los_st_t;

    cac_los_st_t s_q, s_d;

    // ==========================================================
    // missing pulse detection
    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], ref_clk_pin};
        if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.level) begin
            s_d.level = s_q.sync[2];
            s_d.cnt = 16'h0000;
            s_d.los = 1'b0;
        end else if (s_q.cnt >= 16'(LOS_CYCLES - 1)) begin
            s_d.los = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ref_level = s_q.level;
    assign los = s_q.los;

endmodule : cac_los_mon

// ==== cac_out_ctl.sv ====
`timescale 1ns/1ps
module cac_out_ctl import cac_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_down,
    input wire logic bypass,
    input wire logic ref_level,
    input wire logic [HALF_W-1:0] half,
    input wire logic [SKEW_W-1:0] skew,
    input wire logic realign,
    output logic clk_out
);

    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic synth;
        logic out;
    } cac_out_st_t;

    cac_out_st_t s_q, s_d;

    // ==========================================================
    // divider with per-output phase offset
    always_comb begin
        s_d = s_q;
        if (realign) begin
            s_d.cnt = HALF_W'(skew);
            s_d.synth = 1'b0;
        end else if (s_q.cnt >= half - HALF_W'(1)) begin
            s_d.cnt = '0;
            s_d.synth = ~s_q.synth;
        end else begin
            s_d.cnt = s_q.cnt + HALF_W'(1);
        end
        if (power_down) begin
            s_d.out = 1'b0;
        end else if (bypass) begin
            s_d.out = ref_level;
        end else begin
            s_d.out = s_q.synth;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_out = s_q.out;

endmodule : cac_out_ctl

// ==== cac_clock_ctl.sv ====
`timescale 1ns/1ps
module cac_clock_ctl import cac_pkg::*; #(
    parameter int LOS_CYCLES = LOS_CYC,
    parameter int CAL_CYCLES = CAL_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_clock_1,
    input wire logic ref_clock_2,
    input wire logic ref_clock_3,
    output logic in1_invalid_out,
    output logic in1_invalid_oe,
    output logic in2_invalid_out,
    output logic in2_invalid_oe,
    output logic in3_invalid_out,
    output logic in3_invalid_oe,
    output logic [NUM_OUT-1:0] clk_out,
    output logic [NUM_OUT-1:0] clk_out_oe,
    input wire logic [FREQ_W-1:0] loop_freq_word,
    output logic [FREQ_W-1:0] dco_freq_word,
    output logic dco_freeze,
    output logic [PHASE_W-1:0] in_phase_code,
    output logic calibrating,
    output logic irq
);

    if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_chk
        $error("cac_clock_ctl: CAL_CYCLES out of range");
    end

    typedef struct packed {
        logic aw_full;
        logic w_full;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        cac_cfg_t cfg;
        logic cal_busy;
        logic [15:0] cal_cnt;
        logic [NUM_IN-1:0] los_prev;
        logic [INT_W-1:0] int_stat;
        logic [FREQ_W-1:0] freq;
        logic freeze;
        logic realign;
        logic [NUM_IN-1:0] pin_val;
        logic [NUM_IN-1:0] pin_oe;
    } cac_st_t;

    cac_st_t s_q, s_d;

    logic [NUM_IN-1:0] ref_pins;
    logic [NUM_IN-1:0] ref_level;
    logic [NUM_IN-1:0] los;
    logic [NUM_OUT-1:0] out_clk;
    logic bypass_ref;
    logic wr_fire;
    logic rd_fire;

    // ==========================================================
    // address decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            CTRL_OFS, PD_OFS, PHASE_OFS, SKEW_OFS, STATUS_OFS,
            INT_STAT_OFS, INT_CLR_OFS, INT_EN_OFS, FREQ_OFS,
            DIV_OFS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // ==========================================================
    // input monitors
    assign ref_pins = {ref_clock_3, ref_clock_2, ref_clock_1};

    generate
        for (genvar i = 0; i < NUM_IN; i++) begin : g_in
            cac_los_mon #(
                .LOS_CYCLES(LOS_CYCLES)
            ) u_los (
                .aclk(aclk),
                .aresetn(aresetn),
                .ref_clk_pin(ref_pins[i]),
                .ref_level(ref_level[i]),
                .los(los[i])
            );
        end
    endgenerate

    assign bypass_ref = (s_q.cfg.sel < SEL_W'(NUM_IN)) ?
        ref_level[s_q.cfg.sel] : 1'b0;

    // ==========================================================
    // output paths
    generate
        for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
            cac_out_ctl u_out (
                .aclk(aclk),
                .aresetn(aresetn),
                .power_down(s_q.cfg.pd[j]),
                .bypass(s_q.cfg.bypass),
                .ref_level(bypass_ref),
                .half(s_q.cfg.half),
                .skew(s_q.cfg.skew[j*SKEW_W +: SKEW_W]),
                .realign(s_q.realign),
                .clk_out(out_clk[j])
            );
        end
    endgenerate

    // ==========================================================
    // bus handshake
    assign s_axi_awready = !s_q.aw_full;
    assign s_axi_wready = !s_q.w_full;
    assign s_axi_arready = !s_q.rvalid;
    assign wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign rd_fire = s_axi_arvalid && !s_q.rvalid;

    // ==========================================================
    // next state
    always_comb begin
        logic [DATA_W-1:0] word;
        logic [DATA_W-1:0] rd;
        logic [NUM_IN-1:0] los_rise;
        logic [INT_W-1:0] ev;
        logic [INT_W-1:0] clr;
        word = '0;
        rd = '0;
        clr = '0;
        los_rise = '0;
        ev = '0;
        s_d = s_q;
        s_d.realign = 1'b0;

        // write channels taken in either order
        if (s_axi_awvalid && !s_q.aw_full) begin
            s_d.aw_full = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_full) begin
            s_d.w_full = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = is_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_q.awaddr)
                CTRL_OFS: begin
                    word = {
                        25'h0000000,
                        s_q.cfg.sel,
                        s_q.cfg.pin_en,
                        s_q.cfg.polarity,
                        s_q.cfg.bypass
                    };
                    word = merge(word, s_q.wdata, s_q.wstrb);
                    s_d.cfg.bypass = word[CTRL_BYPASS_BIT];
                    s_d.cfg.polarity = word[CTRL_POL_BIT];
                    s_d.cfg.pin_en = word[CTRL_PIN_EN_LSB +: NUM_IN];
                    s_d.cfg.sel = word[CTRL_SEL_LSB +: SEL_W];
                end
                PD_OFS: begin
                    word = merge({27'h0000000, s_q.cfg.pd},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.pd = word[NUM_OUT-1:0];
                end
                PHASE_OFS: begin
                    word = merge({24'h000000, s_q.cfg.phase},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.phase = word[PHASE_W-1:0];
                end
                SKEW_OFS: begin
                    word = merge({12'h000, s_q.cfg.skew},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.skew = word[NUM_OUT*SKEW_W-1:0];
                    s_d.realign = 1'b1;
                end
                INT_CLR_OFS: begin
                    word = merge('0, s_q.wdata, s_q.wstrb);
                    clr = word[INT_W-1:0];
                end
                INT_EN_OFS: begin
                    word = merge({28'h0000000, s_q.cfg.int_en},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.int_en = word[INT_W-1:0];
                end
                DIV_OFS: begin
                    word = merge({24'h000000, s_q.cfg.half},
                        s_q.wdata, s_q.wstrb);
                    if (word[HALF_W-1:0] != '0) begin
                        s_d.cfg.half = word[HALF_W-1:0];
                    end
                    s_d.realign = 1'b1;
                end
                default: begin
                    word = '0;
                end
            endcase
        end

        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            unique case (s_axi_araddr)
                CTRL_OFS: rd = {
                    25'h0000000,
                    s_q.cfg.sel,
                    s_q.cfg.pin_en,
                    s_q.cfg.polarity,
                    s_q.cfg.bypass
                };
                PD_OFS: rd = {27'h0000000, s_q.cfg.pd};
                PHASE_OFS: rd = {24'h000000, s_q.cfg.phase};
                SKEW_OFS: rd = {12'h000, s_q.cfg.skew};
                STATUS_OFS: begin
                    rd[ST_LOS_LSB +: NUM_IN] = los;
                    rd[ST_CAL_BIT] = s_q.cal_busy;
                    rd[ST_FREEZE_BIT] = s_q.freeze;
                end
                INT_STAT_OFS: rd = {28'h0000000, s_q.int_stat};
                INT_EN_OFS: rd = {28'h0000000, s_q.cfg.int_en};
                FREQ_OFS: rd = {8'h00, s_q.freq};
                DIV_OFS: rd = {24'h000000, s_q.cfg.half};
                default: rd = '0;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata = rd;
            s_d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // self-calibration after reset release
        if (s_q.cal_busy) begin
            if (s_q.cal_cnt >= 16'(CAL_CYCLES - 1)) begin
                s_d.cal_busy = 1'b0;
                s_d.realign = 1'b1;
            end else begin
                s_d.cal_cnt = s_q.cal_cnt + 16'h0001;
            end
        end

        // frequency hold on alarm of the selected input
        s_d.freeze = (s_q.cfg.sel < SEL_W'(NUM_IN)) ?
            los[s_q.cfg.sel] : 1'b1;
        if (!s_q.freeze && !s_q.cal_busy) begin
            s_d.freq = loop_freq_word;
        end

        // indicator pins
        for (int i = 0; i < NUM_IN; i++) begin
            s_d.pin_val[i] = los[i] ^ s_q.cfg.polarity;
            s_d.pin_oe[i] = s_q.cfg.pin_en[i];
        end

        // sticky events, set wins over clear
        los_rise = los & ~s_q.los_prev;
        s_d.los_prev = los;
        ev = {s_q.cal_busy && !s_d.cal_busy, los_rise};
        s_d.int_stat = (s_q.int_stat & ~clr) | ev;
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.cfg <= CFG_RST;
            s_q.cal_busy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    assign in1_invalid_out = s_q.pin_val[0];
    assign in2_invalid_out = s_q.pin_val[1];
    assign in3_invalid_out = s_q.pin_val[2];
    assign in1_invalid_oe = aresetn && s_q.pin_oe[0];
    assign in2_invalid_oe = aresetn && s_q.pin_oe[1];
    assign in3_invalid_oe = aresetn && s_q.pin_oe[2];

    assign clk_out = out_clk;
    assign clk_out_oe = {NUM_OUT{aresetn && !s_q.cal_busy}};

    assign dco_freq_word = s_q.freq;
    assign dco_freeze = s_q.freeze;
    assign in_phase_code = s_q.cfg.phase;
    assign calibrating = s_q.cal_busy;
    assign irq = |(s_q.int_stat & s_q.cfg.int_en);

endmodule : cac_clock_ctl

// ==== cac_board_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// board side: input clocks and indicator pin levels
module cac_board_model import cac_pkg::*; #(
    parameter int HALF_NS = 20
) (
    input wire logic [NUM_IN-1:0] run,
    input wire logic [NUM_IN-1:0] pin_out,
    input wire logic [NUM_IN-1:0] pin_oe,
    output logic [NUM_IN-1:0] ref_clk,
    output logic [NUM_IN-1:0] pin_lvl
);
    logic [NUM_IN-1:0] last_q;
    initial begin
        ref_clk = '0;
        last_q = '0;
    end
    // stopped inputs stand still at their last level
    always #(HALF_NS) ref_clk = ref_clk ^ run;
    // released pin shows the inverse of its last driven level
    always @* begin
        for (int i = 0; i < NUM_IN; i++) begin
            if (pin_oe[i]) begin
                last_q[i] = pin_out[i];
            end
        end
        pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~last_q);
    end
endmodule : cac_board_model

// ==== cac_clock_ctl_sva.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checks
module cac_clock_ctl_sva import cac_pkg::*; #(
    parameter int LOS_CYCLES = LOS_CYC,
    parameter int CAL_CYCLES = CAL_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic in1_invalid_oe,
    input wire logic in2_invalid_oe,
    input wire logic in3_invalid_oe,
    input wire logic [NUM_OUT-1:0] clk_out_oe,
    input wire logic [FREQ_W-1:0] dco_freq_word,
    input wire logic dco_freeze,
    input wire logic [PHASE_W-1:0] in_phase_code,
    input wire logic calibrating
);
    logic [15:0] cal_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_cnt_q <= 16'h0000;
        end else if (calibrating) begin
            cal_cnt_q <= cal_cnt_q + 16'h0001;
        end
    end
    AST_RST_CLK_HIZ: assert property (@(posedge aclk)
        !aresetn |-> clk_out_oe == '0) else $error("clock out driven");
    AST_RST_PIN_HIZ: assert property (@(posedge aclk)
        !aresetn |-> !(in1_invalid_oe || in2_invalid_oe || in3_invalid_oe))
        else $error("indicator driven in reset");
    AST_CAL_START: assert property (@(posedge aclk)
        $rose(aresetn) |-> calibrating) else $error("no calibration");
    AST_CAL_LEN: assert property (@(posedge aclk)
        disable iff (!aresetn) $fell(calibrating) |->
        cal_cnt_q >= CAL_CYCLES - 1 && cal_cnt_q <= CAL_CYCLES + 1)
        else $error("calibration length wrong");
    AST_OE_CAL: assert property (@(posedge aclk)
        disable iff (!aresetn) clk_out_oe == {NUM_OUT{!calibrating}})
        else $error("output enable wrong");
    AST_PIN_EN_WRITE: assert property (@(posedge aclk)
        disable iff (!aresetn) $rose(in1_invalid_oe) |->
        $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("indicator enabled without write");
    AST_PHASE_WRITE: assert property (@(posedge aclk)
        disable iff (!aresetn) !$stable(in_phase_code) && $past(aresetn)
        |-> $past(s_axi_wvalid, 1) || $past(s_axi_wvalid, 2))
        else $error("phase code moved without write");
    AST_FREEZE_HOLD: assert property (@(posedge aclk)
        disable iff (!aresetn) dco_freeze && $past(dco_freeze) |->
        $stable(dco_freq_word)) else $error("held word moved");
    AST_FREEZE_CAL: assert property (@(posedge aclk)
        disable iff (!aresetn) calibrating && $past(calibrating) &&
        $past(aresetn) |-> $stable(dco_freq_word))
        else $error("word moved in calibration");
endmodule : cac_clock_ctl_sva

bind cac_clock_ctl cac_clock_ctl_sva #(
    .LOS_CYCLES(LOS_CYCLES),
    .CAL_CYCLES(CAL_CYCLES)
) u_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_wvalid(s_axi_wvalid),
    .in1_invalid_oe(in1_invalid_oe),
    .in2_invalid_oe(in2_invalid_oe),
    .in3_invalid_oe(in3_invalid_oe),
    .clk_out_oe(clk_out_oe),
    .dco_freq_word(dco_freq_word),
    .dco_freeze(dco_freeze),
    .in_phase_code(in_phase_code),
    .calibrating(calibrating)
);

// ==== cac_clock_ctl_tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// bench top
module cac_clock_ctl_tb import cac_pkg::*;;
    localparam int LOS = 16;
    localparam int CAL = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rd_d;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid;
    logic irq, calibrating, dco_freeze;
    logic [NUM_IN-1:0] run = 3'h7;
    wire [NUM_IN-1:0] refc, pout, poe, plvl;
    logic [NUM_OUT-1:0] clk_out, clk_out_oe;
    logic [FREQ_W-1:0] loop_w = '0, dco_w;
    logic [PHASE_W-1:0] phase;
    int mismatches = 0;
    int check_count = 0;
    int n;

    always #4 aclk = ~aclk;

    cac_clock_ctl #(.LOS_CYCLES(LOS), .CAL_CYCLES(CAL)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ref_clock_1(refc[0]),
        .ref_clock_2(refc[1]), .ref_clock_3(refc[2]),
        .in1_invalid_out(pout[0]), .in1_invalid_oe(poe[0]),
        .in2_invalid_out(pout[1]), .in2_invalid_oe(poe[1]),
        .in3_invalid_out(pout[2]), .in3_invalid_oe(poe[2]),
        .clk_out(clk_out), .clk_out_oe(clk_out_oe),
        .loop_freq_word(loop_w), .dco_freq_word(dco_w),
        .dco_freeze(dco_freeze), .in_phase_code(phase),
        .calibrating(calibrating), .irq(irq)
    );

    cac_board_model u_board (
        .run(run), .pin_out(pout), .pin_oe(poe),
        .ref_clk(refc), .pin_lvl(plvl)
    );

    // ==========================================================
    // helpers
    task automatic report_and_stop();
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        axi_rd(a, rd_d, rs);
        chk(rd_d, e);
    endtask : rchk

    task automatic tog(input int b, output int cnt);
        logic p;
        cnt = 0;
        p = clk_out[b];
        repeat (64) begin
            @(posedge aclk);
            if (clk_out[b] !== p) cnt++;
            p = clk_out[b];
        end
    endtask : tog

    // ==========================================================
    // scenarios
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        chk(clk_out_oe, 32'h0);
        chk(poe, 32'h0);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(calibrating, 32'h1);
        for (n = 0; n < 100 && calibrating; n++) @(posedge aclk);
        chk(calibrating, 32'h0);
        chk(clk_out_oe, 32'h1F);
    endtask : do_reset

    task automatic t_regs();
        axi_wr(CTRL_OFS, 32'h7F, rs);
        axi_wr(PHASE_OFS, 32'h33, rs);
        axi_wr(DIV_OFS, 32'h9, rs);
        chk(poe, 32'h7);
        do_reset();
        rchk(CTRL_OFS, 32'h0);
        rchk(PD_OFS, 32'h0);
        rchk(PHASE_OFS, 32'h0);
        rchk(DIV_OFS, 32'h4);
        rchk(INT_EN_OFS, 32'h0);
        axi_rd(8'h40, rd_d, rs);
        chk(rs, RESP_SLVERR);
    endtask : t_regs

    task automatic t_pins();
        axi_wr(CTRL_OFS, 32'h1C, rs);
        repeat (4) @(posedge aclk);
        chk(plvl, 32'h0);
        run <= 3'b101;
        repeat (LOS + 40) @(posedge aclk);
        chk(plvl, 32'h2);
        rchk(STATUS_OFS, 32'h2);
        axi_wr(CTRL_OFS, 32'h1E, rs);
        repeat (4) @(posedge aclk);
        chk(plvl, 32'h5);
        axi_wr(CTRL_OFS, 32'h16, rs);
        chk(poe, 32'h5);
    endtask : t_pins

    task automatic t_irq();
        rchk(INT_STAT_OFS, 32'hA);
        chk(irq, 32'h0);
        axi_wr(INT_EN_OFS, 32'h2, rs);
        chk(irq, 32'h1);
        axi_wr(INT_CLR_OFS, 32'hA, rs);
        chk(irq, 32'h0);
        rchk(INT_STAT_OFS, 32'h0);
    endtask : t_irq

    task automatic t_freeze();
        axi_wr(CTRL_OFS, 32'h0, rs);
        loop_w <= 24'h123456;
        repeat (4) @(posedge aclk);
        chk(dco_w, 32'h123456);
        axi_wr(CTRL_OFS, 32'h20, rs);
        loop_w <= 24'h654321;
        repeat (4) @(posedge aclk);
        chk(dco_freeze, 32'h1);
        chk(dco_w, 32'h123456);
        run <= 3'b111;
        repeat (20) @(posedge aclk);
        chk(dco_freeze, 32'h0);
        chk(dco_w, 32'h654321);
    endtask : t_freeze

    task automatic t_out();
        axi_wr(CTRL_OFS, 32'h0, rs);
        axi_wr(PD_OFS, 32'h1, rs);
        run <= 3'b110;
        tog(0, n);
        chk(n, 32'h0);
        chk(clk_out[0], 32'h0);
        tog(1, n);
        chk(n, 32'h10);
        axi_wr(CTRL_OFS, 32'h1, rs);
        tog(1, n);
        chk(n, 32'h0);
        run <= 3'b111;
        tog(1, n);
        chk(n > 20, 32'h1);
        axi_wr(CTRL_OFS, 32'h0, rs);
    endtask : t_out

    task automatic t_phase();
        axi_wr(PHASE_OFS, 32'h5A, rs);
        chk(phase, 32'h5A);
        axi_wr(PHASE_OFS, 32'hFF, rs);
        chk(phase, 32'hFF);
        axi_wr(SKEW_OFS, 32'h3, rs);
        rchk(SKEW_OFS, 32'h3);
        axi_wr(8'h40, 32'h1, rs);
        chk(rs, RESP_SLVERR);
    endtask : t_phase

    initial begin
        @(posedge aclk);
        do_reset();
        t_regs();
        t_pins();
        t_irq();
        t_freeze();
        t_out();
        t_phase();
        report_and_stop();
    end

    initial begin
        #(8 * 20000);
        mismatches++;
        report_and_stop();
    end
endmodule : cac_clock_ctl_tb
